// [core/toc_overcurrent.v]
// Purpose: three-phase definite/inverse time overcurrent protection
// Assumes: magnitudes are fundamental RMS, synchronous to pclk
// Notes:   timing advances on a 1 ms tick; one shared divider
//
// How it works
// - start while above threshold, trip after delay
// - three phases evaluated independently from fundamentals
// - general start and trip from phase flags
// - mode: off, definite, four IEC, seven ANSI
// - start threshold 10..3000 percent, default 200
// - time multiplier 0.05..15.00 in 0.01 steps
// - inverse minimum delay 40..60000 ms, default 100
// - definite delay 40..60000 ms
// - IEC reset delay 60..60000 ms
// - per-phase start and trip flags exposed
// - inverse time formula, held above twenty times
// - inverse delay is max of minimum and curve
// - inverse operation guaranteed above 1.1 times
// - IEC fixed reset, ANSI reset by formula
`timescale 1ns/1ps
`include "toc_consts.vh"
module toc_overcurrent #(
	parameter MAG_W       = 16,
	parameter NOM_CURRENT = 16'd1000,
	parameter TICK_CYCLES = `TOC_TICK_CYCLES
) (
	// clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// apb slave
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [7:0]       paddr,
	input  wire [31:0]      pwdata,
	output reg  [31:0]      prdata,
	output reg              pready,
	output reg              pslverr,
	// measurement and block input
	input  wire [MAG_W-1:0] phase1_fundamental_mag,
	input  wire [MAG_W-1:0] phase2_fundamental_mag,
	input  wire [MAG_W-1:0] phase3_fundamental_mag,
	input  wire             function_block_in,
	// protection outputs
	output reg              phase1_start_flag,
	output reg              phase1_trip_flag,
	output reg              phase2_start_flag,
	output reg              phase2_trip_flag,
	output reg              phase3_start_flag,
	output reg              phase3_trip_flag,
	output reg              general_start_out,
	output reg              general_trip_out,
	output reg              irq
);
	localparam S_IDLE  = 5'b00001;
	localparam S_RATIO = 5'b00010;
	localparam S_CURVE = 5'b00100;
	localparam S_SCALE = 5'b01000;
	localparam S_UPD   = 5'b10000;

	reg [3:0]       mode;
	reg [11:0]      start_pct;
	reg [10:0]      tms;
	reg [15:0]      min_dly;
	reg [15:0]      dt_dly;
	reg [15:0]      rst_dly;
	reg [5:0]       int_stat;
	reg [5:0]       int_mask;
	reg [16:0]      tick_cnt;
	reg             tick;
	reg [4:0]       st;
	reg [1:0]       ph;
	reg [MAG_W-1:0] g_lat;
	reg [2:0]       st_flag;
	reg [2:0]       tr_flag;
	reg [2:0]       st_q;
	reg [2:0]       tr_q;
	reg [19:0]      elapsed [0:2];
	reg [19:0]      rcnt [0:2];
	reg [63:0]      div_q;
	reg [63:0]      div_r;
	reg [63:0]      div_d;
	reg [6:0]       div_cnt;
	reg [1:0]       cv_alpha;
	reg [26:0]      cv_k;
	reg [19:0]      cv_c;
	reg [24:0]      cv_kr;
	reg [31:0]      den;
	reg [31:0]      rd_val;
	integer         i;

	wire active = (mode != `TOC_MODE_OFF) && !function_block_in;
	wire dt_mode = (mode == `TOC_MODE_DT);
	wire ansi = (mode >= `TOC_MODE_ANSI0);
	wire wr = psel & penable & pwrite & ~pready;
	// threshold in magnitude units is percent times nominal
	wire [31:0] g100 = g_lat * 32'd100;
	wire [31:0] gs_abs = start_pct * NOM_CURRENT;
	wire op_now = g100 > gs_abs;
	// ratio held at twenty; lifted to 1.1 when started
	wire [20:0] r_lim = (div_q > {43'h0, `TOC_R_HI}) ? `TOC_R_HI
		: div_q[20:0];
	wire [20:0] rc = (op_now && r_lim < `TOC_R_LO) ? `TOC_R_LO : r_lim;
	wire [41:0] rsq_full = rc * rc;
	wire [25:0] r2 = rsq_full[41:16];
	wire [63:0] rem_sh = {div_r[62:0], div_q[63]};
	wire [37:0] k_t = cv_k * tms;
	wire [37:0] kr_t = cv_kr * tms;
	wire [30:0] c_t = cv_c * tms;
	wire [15:0] t_dly = dt_mode ? dt_dly : 16'h0;
	wire [19:0] t_calc = (div_q > 64'h00000000000FFFFF) ? 20'hFFFFF
		: div_q[19:0];
	wire [19:0] op_dly = dt_mode ? {4'h0, t_dly} :
		((t_calc > {4'h0, min_dly}) ? t_calc : {4'h0, min_dly});
	wire [19:0] rs_dly = ansi ? t_calc : {4'h0, rst_dly};
	wire [19:0] el_inc = (elapsed[ph] == 20'hFFFFF) ? elapsed[ph]
		: elapsed[ph] + 20'h00001;
	wire [19:0] rc_inc = rcnt[ph] + 20'h00001;
	wire [5:0] ev = {tr_flag & ~tr_q, st_flag & ~st_q};

	function [4:0] msb32;
		input [31:0] v;
		integer j;
		begin
			msb32 = 5'd0;
			for (j = 0; j < 32; j = j + 1)
				if (v[j])
					msb32 = j[4:0];
		end
	endfunction

	function [15:0] clampv;
		input [31:0] v;
		input [15:0] lo;
		input [15:0] hi;
		begin
			if (v < {16'h0, lo})
				clampv = lo;
			else if (v > {16'h0, hi})
				clampv = hi;
			else
				clampv = v[15:0];
		end
	endfunction

	// clamped settings, cut to the field width on purpose
	wire [15:0] start_clamp = clampv(pwdata, {4'h0, `TOC_START_MIN},
		{4'h0, `TOC_START_MAX});
	wire [15:0] tms_clamp = clampv(pwdata, {5'h0, `TOC_TMS_MIN},
		{5'h0, `TOC_TMS_MAX});

	// curve constants in microseconds
	always @*
	begin
		cv_alpha = 2'd2;
		cv_k = 27'd0;
		cv_c = 20'd0;
		cv_kr = 25'd0;
		case (mode)
		4'h2: begin cv_alpha = 2'd0; cv_k = 27'd140000; end
		4'h3: begin cv_alpha = 2'd1; cv_k = 27'd13500000; end
		4'h4: cv_k = 27'd80000000;
		4'h5: begin cv_alpha = 2'd1; cv_k = 27'd120000000; end
		4'h6:
		begin
			cv_alpha = 2'd0; cv_k = 27'd8600; cv_c = 20'd18500;
			cv_kr = 25'd460000;
		end
		4'h7:
		begin
			cv_alpha = 2'd0; cv_k = 27'd51500; cv_c = 20'd114000;
			cv_kr = 25'd4850000;
		end
		4'h8:
		begin
			cv_k = 27'd19610000; cv_c = 20'd491000; cv_kr = 25'd21600000;
		end
		4'h9:
		begin
			cv_k = 27'd28200000; cv_c = 20'd121700; cv_kr = 25'd29100000;
		end
		4'hA:
		begin
			cv_alpha = 2'd0; cv_k = 27'd86000; cv_c = 20'd185000;
			cv_kr = 25'd4600000;
		end
		4'hB:
		begin
			cv_k = 27'd28550000; cv_c = 20'd712000; cv_kr = 25'd13460000;
		end
		4'hC:
		begin
			cv_k = 27'd64070000; cv_c = 20'd250000; cv_kr = 25'd30000000;
		end
		default: cv_alpha = 2'd2;
		endcase
	end

	// curve denominator in Q16; alpha 0.02 uses 0.02*ln(r), close
	// enough near pickup and cheaper than a true power
	always @*
	begin : den_calc
		reg [4:0]  m;
		reg [31:0] nrm;
		reg [31:0] lg;
		reg [47:0] lgs;
		m = msb32({11'h0, rc});
		nrm = {11'h0, rc} << (5'd31 - m);
		lg = {11'h0, m - 5'd16, 16'h0} + {16'h0, nrm[30:15]};
		lgs = lg * `TOC_LN_A002;
		if (!op_now)
			den = (r2 >= 26'h0010000) ? 32'h1 : 32'h10000 - {6'h0, r2};
		else if (cv_alpha == 2'd0)
			den = {16'h0, lgs[31:16]};
		else if (cv_alpha == 2'd1)
			den = {11'h0, rc} - 32'h10000;
		else
			den = {6'h0, r2} - 32'h10000;
		if (den == 32'h0)
			den = 32'h1;
	end

	// 1 ms tick
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_cnt <= 17'h0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (tick_cnt == TICK_CYCLES - 1);
			if (tick_cnt == TICK_CYCLES - 1)
				tick_cnt <= 17'h0;
			else
				tick_cnt <= tick_cnt + 17'h1;
		end
	end

	// timing engine, one phase after another each tick
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= S_IDLE;
			ph <= 2'd0;
			g_lat <= {MAG_W{1'b0}};
			st_flag <= 3'h0;
			tr_flag <= 3'h0;
			div_q <= 64'h0;
			div_r <= 64'h0;
			div_d <= 64'h1;
			div_cnt <= 7'h0;
			for (i = 0; i < 3; i = i + 1)
			begin
				elapsed[i] <= 20'h0;
				rcnt[i] <= 20'h0;
			end
		end
		else if (!active)
		begin
			st <= S_IDLE;
			div_cnt <= 7'h0;
			st_flag <= 3'h0;
			tr_flag <= 3'h0;
			for (i = 0; i < 3; i = i + 1)
			begin
				elapsed[i] <= 20'h0;
				rcnt[i] <= 20'h0;
			end
		end
		else
		begin
			if (div_cnt != 7'h0)
			begin
				div_cnt <= div_cnt - 7'h1;
				if (rem_sh >= div_d)
				begin
					div_r <= rem_sh - div_d;
					div_q <= {div_q[62:0], 1'b1};
				end
				else
				begin
					div_r <= rem_sh;
					div_q <= {div_q[62:0], 1'b0};
				end
			end
			case (st)
			S_IDLE:
				if (tick)
				begin
					ph <= 2'd0;
					g_lat <= phase1_fundamental_mag;
					st <= S_RATIO;
				end
			S_RATIO:
				if (div_cnt == 7'h0)
				begin
					div_q <= {16'h0, g100, 16'h0}; // ratio in Q16
					div_r <= 64'h0;
					div_d <= {32'h0, gs_abs};
					div_cnt <= 7'd64;
					st <= S_CURVE;
				end
			S_CURVE:
				if (div_cnt == 7'h0)
				begin
					div_q <= op_now ? {10'h0, k_t, 16'h0}
						: {10'h0, kr_t, 16'h0};
					div_r <= 64'h0;
					div_d <= {32'h0, den};
					div_cnt <= 7'd64;
					st <= S_SCALE;
				end
			S_SCALE:
				if (div_cnt == 7'h0)
				begin
					div_q <= div_q + (op_now ? {33'h0, c_t} : 64'h0);
					div_r <= 64'h0;
					div_d <= `TOC_SCALE_DIV;
					div_cnt <= 7'd64;
					st <= S_UPD;
				end
			S_UPD:
				if (div_cnt == 7'h0)
				begin
					if (op_now)
					begin
						st_flag[ph] <= 1'b1;
						rcnt[ph] <= 20'h0;
						elapsed[ph] <= el_inc;
						if (el_inc >= op_dly)
							tr_flag[ph] <= 1'b1;
					end
					else
					begin
						st_flag[ph] <= 1'b0;
						tr_flag[ph] <= 1'b0;
						if (dt_mode || rc_inc >= rs_dly)
						begin
							elapsed[ph] <= 20'h0;
							rcnt[ph] <= 20'h0;
						end
						else
							rcnt[ph] <= rc_inc;
					end
					if (ph == 2'd2)
						st <= S_IDLE;
					else
					begin
						ph <= ph + 2'd1;
						g_lat <= (ph == 2'd0) ? phase2_fundamental_mag
							: phase3_fundamental_mag;
						st <= S_RATIO;
					end
				end
			default: st <= S_IDLE;
			endcase
		end
	end

	// outputs, events and registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode <= `TOC_MODE_OFF;
			start_pct <= `TOC_START_RST;
			tms <= `TOC_TMS_RST;
			min_dly <= `TOC_DLY_RST;
			dt_dly <= `TOC_DLY_RST;
			rst_dly <= `TOC_DLY_RST;
			int_stat <= 6'h0;
			int_mask <= 6'h0;
			st_q <= 3'h0;
			tr_q <= 3'h0;
			{phase1_start_flag, phase2_start_flag, phase3_start_flag} <= 3'h0;
			{phase1_trip_flag, phase2_trip_flag, phase3_trip_flag} <= 3'h0;
			general_start_out <= 1'b0;
			general_trip_out <= 1'b0;
			irq <= 1'b0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			st_q <= st_flag;
			tr_q <= tr_flag;
			phase1_start_flag <= st_flag[0];
			phase2_start_flag <= st_flag[1];
			phase3_start_flag <= st_flag[2];
			phase1_trip_flag <= tr_flag[0];
			phase2_trip_flag <= tr_flag[1];
			phase3_trip_flag <= tr_flag[2];
			general_start_out <= |st_flag;
			general_trip_out <= |tr_flag;
			irq <= |(int_stat & int_mask);
			// a new event wins over a write-one clear
			if (wr && paddr == `TOC_OFF_INTSTAT)
				int_stat <= (int_stat & ~pwdata[5:0]) | ev;
			else
				int_stat <= int_stat | ev;
			pready <= psel & penable & ~pready;
			pslverr <= 1'b0;
			if (psel & penable & ~pready)
			begin
				prdata <= pwrite ? 32'h0 : rd_val;
				pslverr <= (paddr > `TOC_OFF_INTMASK) || (paddr[1:0] != 2'b00);
			end
			if (wr)
				case (paddr)
				`TOC_OFF_CTRL:
					mode <= (pwdata[31:0] > {28'h0, `TOC_MODE_MAX}) ?
						`TOC_MODE_OFF : pwdata[3:0];
				`TOC_OFF_START:
					start_pct <= start_clamp[11:0];
				`TOC_OFF_TMS:
					tms <= tms_clamp[10:0];
				`TOC_OFF_MINDLY:
					min_dly <= clampv(pwdata, `TOC_DLY_MIN, `TOC_DLY_MAX);
				`TOC_OFF_DTDLY:
					dt_dly <= clampv(pwdata, `TOC_DLY_MIN, `TOC_DLY_MAX);
				`TOC_OFF_RSTDLY:
					rst_dly <= clampv(pwdata, `TOC_RDLY_MIN, `TOC_DLY_MAX);
				`TOC_OFF_INTMASK:
					int_mask <= pwdata[5:0];
				default: int_mask <= int_mask;
				endcase
		end
	end

	always @*
	begin
		rd_val = 32'h0;
		case (paddr)
		`TOC_OFF_CTRL:    rd_val = {28'h0, mode};
		`TOC_OFF_START:   rd_val = {20'h0, start_pct};
		`TOC_OFF_TMS:     rd_val = {21'h0, tms};
		`TOC_OFF_MINDLY:  rd_val = {16'h0, min_dly};
		`TOC_OFF_DTDLY:   rd_val = {16'h0, dt_dly};
		`TOC_OFF_RSTDLY:  rd_val = {16'h0, rst_dly};
		`TOC_OFF_STATUS:
			rd_val = {23'h0, active, general_trip_out, general_start_out,
				tr_flag, st_flag};
		`TOC_OFF_INTSTAT: rd_val = {26'h0, int_stat};
		`TOC_OFF_INTMASK: rd_val = {26'h0, int_mask};
		default:          rd_val = 32'h0;
		endcase
	end
endmodule

// [core/toc_consts.vh]
// Purpose: constants of the three-phase time overcurrent block
// Assumes: 32-bit APB, byte addresses, 125 MHz pclk
// Notes:   times in ms unless named otherwise
`ifndef TOC_CONSTS_VH
`define TOC_CONSTS_VH
// register byte offsets
`define TOC_OFF_CTRL     8'h00
`define TOC_OFF_START    8'h04
`define TOC_OFF_TMS      8'h08
`define TOC_OFF_MINDLY   8'h0C
`define TOC_OFF_DTDLY    8'h10
`define TOC_OFF_RSTDLY   8'h14
`define TOC_OFF_STATUS   8'h18
`define TOC_OFF_INTSTAT  8'h1C
`define TOC_OFF_INTMASK  8'h20
// operation modes: 2..5 IEC curves, 6..12 ANSI curves
`define TOC_MODE_OFF     4'h0
`define TOC_MODE_DT      4'h1
`define TOC_MODE_ANSI0   4'h6
`define TOC_MODE_MAX     4'hC
// setting ranges and reset values (percent, hundredths, ms)
`define TOC_START_MIN    12'h00A
`define TOC_START_MAX    12'hBB8
`define TOC_START_RST    12'h0C8
`define TOC_TMS_MIN      11'h005
`define TOC_TMS_MAX      11'h5DC
`define TOC_TMS_RST      11'h064
`define TOC_DLY_MIN      16'h0028
`define TOC_DLY_MAX      16'hEA60
`define TOC_RDLY_MIN     16'h003C
`define TOC_DLY_RST      16'h0064
// status bit positions
`define TOC_ST_START     0
`define TOC_ST_TRIP      3
`define TOC_ST_GSTART    6
`define TOC_ST_GTRIP     7
`define TOC_ST_ACTIVE    8
// ratio limits, Q16: 20.0 and 1.1
`define TOC_R_HI         21'h140000
`define TOC_R_LO         21'h01199A
// 0.02*ln2 in Q16, us per ms times hundredths
`define TOC_LN_A002      16'h038D
`define TOC_SCALE_DIV    64'h00000000000186A0
// timing
`define TOC_TICK_NS      1000000
`define TOC_CLK_NS       8
`define TOC_TICK_CYCLES  (`TOC_TICK_NS / `TOC_CLK_NS)
`endif

// [bench/toc_front_end.sv]
// Purpose: measurement front end and block logic beside the block
// Assumes: the test asks for values, this side applies them on pclk
// Notes:   magnitudes hold until asked to change, like a slow filter
`timescale 1ns/1ps
module toc_front_end #(
	parameter MAG_W = 16
) (
	// clock
	input  wire             pclk,
	// values asked for by the test
	input  wire [MAG_W-1:0] req_mag1,
	input  wire [MAG_W-1:0] req_mag2,
	input  wire [MAG_W-1:0] req_mag3,
	input  wire             req_block,
	// towards the protection block
	output logic [MAG_W-1:0] mag1 = '0,
	output logic [MAG_W-1:0] mag2 = '0,
	output logic [MAG_W-1:0] mag3 = '0,
	output logic             block = 1'b0
);
	always @(posedge pclk)
	begin
		mag1 <= req_mag1;
		mag2 <= req_mag2;
		mag3 <= req_mag3;
		block <= req_block;
	end
endmodule

// [bench/toc_checker.sv]
// Purpose: port checks for the overcurrent block
// Assumes: apb answer comes on the edge after the first access cycle
// Notes:   tick timing is left to the bench
`timescale 1ns/1ps
module toc_checker (
	// clock and reset
	input wire       pclk,
	input wire       presetn,
	// apb
	input wire       psel,
	input wire       penable,
	input wire [7:0] paddr,
	input wire       pready,
	input wire       pslverr,
	// block input and flags
	input wire       function_block_in,
	input wire       phase1_start_flag,
	input wire       phase1_trip_flag,
	input wire       phase2_start_flag,
	input wire       phase2_trip_flag,
	input wire       phase3_start_flag,
	input wire       phase3_trip_flag,
	input wire       general_start_out,
	input wire       general_trip_out
);
	wire [2:0] st = {phase3_start_flag, phase2_start_flag,
		phase1_start_flag};
	wire [2:0] tr = {phase3_trip_flag, phase2_trip_flag,
		phase1_trip_flag};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_done;
		psel && penable && pready;
	endsequence
	property p_answer;
		s_access |=> pready;
	endproperty
	a_answer: assert property (p_answer)
		else $error("access not answered");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("ready longer than a cycle");
	property p_err_addr;
		(s_done ##0 (paddr > 8'h20)) |-> pslverr;
	endproperty
	a_err_addr: assert property (p_err_addr)
		else $error("unmapped access without error");
	property p_err_only;
		pslverr |-> pready;
	endproperty
	a_err_only: assert property (p_err_only)
		else $error("error outside answer");
	property p_gstart;
		general_start_out == (|st);
	endproperty
	a_gstart: assert property (p_gstart)
		else $error("general start mismatch");
	property p_gtrip;
		general_trip_out == (|tr);
	endproperty
	a_gtrip: assert property (p_gtrip)
		else $error("general trip mismatch");
	// three cycles leave room for the output register
	property p_block;
		function_block_in [*3] |-> (st == 3'h0) && (tr == 3'h0);
	endproperty
	a_block: assert property (p_block)
		else $error("flags while blocked");
	property p_trip_start;
		(tr & ~st) == 3'h0;
	endproperty
	a_trip_start: assert property (p_trip_start)
		else $error("trip without start");
endmodule
bind toc_overcurrent toc_checker toc_checker_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr),
	.function_block_in(function_block_in),
	.phase1_start_flag(phase1_start_flag),
	.phase1_trip_flag(phase1_trip_flag),
	.phase2_start_flag(phase2_start_flag),
	.phase2_trip_flag(phase2_trip_flag),
	.phase3_start_flag(phase3_start_flag),
	.phase3_trip_flag(phase3_trip_flag),
	.general_start_out(general_start_out),
	.general_trip_out(general_trip_out));

// [bench/testbench.sv]
// Purpose: register and protection tests over apb
// Assumes: tick shortened to T cycles, nominal 1000 units
// Notes:   delays measured in ticks from start to trip
`timescale 1ns/1ps
`include "toc_consts.vh"
module testbench;
	localparam int T = 800;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] rq1 = 16'h0;
	logic [15:0] rq2 = 16'h0;
	logic        rqb = 1'b0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         irq;
	wire  [15:0] m1;
	wire  [15:0] m2;
	wire  [15:0] m3;
	wire         blk;
	wire  [7:0]  fl;
	logic [31:0] rd;
	logic        er;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          ncyc = 0;
	int          t0;
	always #4 pclk = ~pclk;
	always @(posedge pclk) ncyc++;
	toc_front_end toc_front_end_i (.pclk(pclk), .req_mag1(rq1),
		.req_mag2(rq2), .req_mag3(16'h0), .req_block(rqb),
		.mag1(m1), .mag2(m2), .mag3(m3), .block(blk));
	toc_overcurrent #(.TICK_CYCLES(T)) toc_overcurrent_i (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phase1_fundamental_mag(m1),
		.phase2_fundamental_mag(m2), .phase3_fundamental_mag(m3),
		.function_block_in(blk), .phase1_start_flag(fl[0]),
		.phase1_trip_flag(fl[1]), .phase2_start_flag(fl[2]),
		.phase2_trip_flag(fl[3]), .phase3_start_flag(fl[4]),
		.phase3_trip_flag(fl[5]), .general_start_out(fl[6]),
		.general_trip_out(fl[7]), .irq(irq));
	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			error_cnt++;
			tally_and_finish();
		end
		else
		begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("register", rd, e);
	endtask
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, e);
		apb(1'b1, a, d);
		rchk(a, e);
	endtask
	// a timeout here means a flag never came
	task automatic wait_fl(input int b);
		int k;
		k = 0;
		while (fl[b] !== 1'b1 && k < 60000)
		begin
			@(posedge pclk);
			k++;
		end
		if (k >= 60000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rchk(`TOC_OFF_CTRL, 32'h0);
		rchk(`TOC_OFF_START, 32'hC8);
		rchk(`TOC_OFF_TMS, 32'h64);
		rchk(`TOC_OFF_MINDLY, 32'h64);
		rchk(`TOC_OFF_DTDLY, 32'h64);
		rchk(`TOC_OFF_RSTDLY, 32'h64);
		$display("defaults done");
		wr_rd(`TOC_OFF_START, 32'h5, 32'hA);
		wr_rd(`TOC_OFF_START, 32'hFFF, 32'hBB8);
		wr_rd(`TOC_OFF_TMS, 32'h1, 32'h5);
		wr_rd(`TOC_OFF_TMS, 32'h7FF, 32'h5DC);
		wr_rd(`TOC_OFF_MINDLY, 32'h0, 32'h28);
		wr_rd(`TOC_OFF_DTDLY, 32'hFFFF, 32'hEA60);
		wr_rd(`TOC_OFF_RSTDLY, 32'h3B, 32'h3C);
		wr_rd(`TOC_OFF_CTRL, 32'hD, 32'h0);
		for (int i = 0; i < 13; i++)
			wr_rd(`TOC_OFF_CTRL, i, i);
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped error", {31'h0, er}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		$display("settings done");
		wr_rd(`TOC_OFF_START, 32'hC8, 32'hC8);
		wr_rd(`TOC_OFF_DTDLY, 32'h28, 32'h28);
		wr_rd(`TOC_OFF_CTRL, 32'h1, 32'h1);
		rq2 <= 16'h0BB8;
		wait_fl(2);
		t0 = ncyc;
		chk("flags", {24'h0, fl}, 32'h44);
		rchk(`TOC_OFF_INTSTAT, 32'h2);
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, `TOC_OFF_INTMASK, 32'h2);
		repeat (2) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h1);
		apb(1'b1, `TOC_OFF_INTSTAT, 32'h2);
		repeat (2) @(posedge pclk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		wait_fl(3);
		chk("definite ticks", (ncyc - t0 + T / 2) / T, 39);
		apb(1'b0, `TOC_OFF_STATUS, 32'h0);
		chk("status", rd, 32'h1D2);
		$display("definite done");
		rqb <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("blocked", {24'h0, fl}, 32'h0);
		rq2 <= 16'h0;
		repeat (2 * T) @(posedge pclk);
		rqb <= 1'b0;
		$display("block done");
		// curve time 35 ms at the clamp, so the minimum must win
		wr_rd(`TOC_OFF_TMS, 32'h5, 32'h5);
		wr_rd(`TOC_OFF_MINDLY, 32'h2D, 32'h2D);
		wr_rd(`TOC_OFF_CTRL, 32'h3, 32'h3);
		rq1 <= 16'h9C40;
		wait_fl(0);
		t0 = ncyc;
		wait_fl(1);
		chk("inverse ticks", (ncyc - t0 + T / 2) / T, 44);
		rq1 <= 16'h0;
		$display("inverse done");
		tally_and_finish();
	end
endmodule
